// *** inc/olar_regs.svh ***
// constants for the overload latch and auto recycle block
`ifndef OLAR_REGS_SVH
`define OLAR_REGS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define OLAR_AW 8
`define OLAR_OFF_PLATE 8'h00
`define OLAR_OFF_SCREEN 8'h04
`define OLAR_OFF_DRIVER 8'h0c
`define OLAR_OFF_REFL 8'h08
`define OLAR_OFF_STATUS 8'h10
`define OLAR_LVL_W 12
`define OLAR_LVL_RST 12'hfff
`define OLAR_RESP_OK 2'h0
`define OLAR_RESP_DEC 2'h3
// status word fields
`define OLAR_ST_LATCH 3:0
`define OLAR_ST_BLOCK 4
`define OLAR_ST_COUNT 7:5
`define OLAR_ST_READY 8
`define OLAR_ST_PLATE 9
`define OLAR_ST_LIM4 10
// ----------------------------------------
// fault sources and synchronised pins
// ----------------------------------------
`define OLAR_SRC_PLATE 0
`define OLAR_SRC_SCREEN 1
`define OLAR_SRC_REFL 2
`define OLAR_SRC_DRIVER 3
`define OLAR_SY_W 12
`define OLAR_SY_FRST 0
`define OLAR_SY_ALLOW 1
`define OLAR_SY_TEST 2
`define OLAR_SY_STRAP 3
`define OLAR_SY_PHASE 4
`define OLAR_SY_CAGE 5
`define OLAR_SY_AIR 6
`define OLAR_SY_TEMP 7
`define OLAR_SY_FIL 8
`define OLAR_SY_SUPPLY 9
`define OLAR_SY_REFEN 10
`define OLAR_SY_PLON 11
// ----------------------------------------
// timing
// ----------------------------------------
`define OLAR_CLK_KHZ 25000
`define OLAR_DELAY_MS 500
`define OLAR_PULSE_MS 500
`define OLAR_WIN_MS 30000
`define OLAR_WARM_MS 30000
`define OLAR_HOLD_MS 2000
`define OLAR_LIM2 3'h2
`define OLAR_LIM4 3'h4
`define OLAR_STRAP_WAIT 2'h3
`endif

// *** inc/olar_pkg.sv ***
// types for the overload latch and auto recycle block
package olar_pkg;
  typedef logic [23:0] olar_stmr_t;
  typedef logic [29:0] olar_ltmr_t;
  typedef enum logic [1:0] {OLAR_IDLE, OLAR_DELAY, OLAR_PULSE} olar_state_t;
  typedef struct packed {
    logic [11:0] s1;
    logic [11:0] s2;
  } olar_sync_t;
  typedef struct packed {
    logic [3:0] trip_prev;
    logic [3:0] latch;
    logic plate_en;
    logic plate_on_cmd;
    logic pulse_lamp;
    olar_state_t st;
    olar_stmr_t tmr;
    logic win_run;
    olar_ltmr_t win_tmr;
    logic [2:0] rcnt;
    logic blocked;
    logic test_prev;
    logic lim4;
    logic [1:0] strap_cnt;
    olar_ltmr_t warm;
    logic warm_done;
    logic outage;
    logic lost;
    olar_ltmr_t hold;
    logic pwr_cmd;
    olar_stmr_t pwr_tmr;
    logic [4:0] lamps;
    logic [3:0][11:0] lvl;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } olar_state_s_t;
endpackage

// *** rtl/olar_sync.sv ***
// two-flop synchroniser for the panel pins
`timescale 1ns/1ns
`include "olar_regs.svh"
module olar_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`OLAR_SY_W-1:0] pins,
  output logic [`OLAR_SY_W-1:0] pins_s
);
  olar_pkg::olar_sync_t s_q;
  olar_pkg::olar_sync_t s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_s = s_q.s2;
endmodule

// *** rtl/olar_top.sv ***
// overload fault latches, auto recycle, filament interlock chain
// Operation
// - compare each supply current against its trip level
// - any tripped source removes plate enable
// - trip drops plate enable at once
// - one fault latch and lamp per source
// - fault lamps clear only by fault reset
// - fault pulses ORed into recycle trigger
// - half second delay then half second pulse
// - restart pulse drives plate-on and pulse lamp
// - restarts limited per 30 second window
// - strap picks two or four attempts
// - count reaching limit blocks and lights lockout
// - window end clears counter and lockout
// - allow switch off disables automatic restart
// - test button injects trigger pulse only
// - interlock lamps form ordered series chain
// - phase good needs monitor report
// - ready only after warm-up interval
// - warm-up survives short outage, restore pulses power-on
// - reflected trip needs protect enable
// - plate enable only after warm-up stage done
`timescale 1ns/1ns
`include "olar_regs.svh"
module olar_top #(
  parameter int DELAY_CYC = `OLAR_DELAY_MS * `OLAR_CLK_KHZ,
  parameter int PULSE_CYC = `OLAR_PULSE_MS * `OLAR_CLK_KHZ,
  parameter int WIN_CYC = `OLAR_WIN_MS * `OLAR_CLK_KHZ,
  parameter int WARM_CYC = `OLAR_WARM_MS * `OLAR_CLK_KHZ,
  parameter int HOLD_CYC = `OLAR_HOLD_MS * `OLAR_CLK_KHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`OLAR_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`OLAR_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`OLAR_LVL_W-1:0] plate_current,
  input wire logic [`OLAR_LVL_W-1:0] screen_current,
  input wire logic [`OLAR_LVL_W-1:0] driver_current,
  input wire logic [`OLAR_LVL_W-1:0] reflected_power,
  input wire logic reflected_protect_enable,
  input wire logic fault_reset_btn,
  input wire logic restart_allow_switch,
  input wire logic recycle_test_btn,
  input wire logic four_attempt_strap,
  input wire logic phase_monitor_ok,
  input wire logic cage_cover_closed,
  input wire logic airflow_ok,
  input wire logic exhaust_temp_ok,
  input wire logic filament_on,
  input wire logic supply_ok,
  input wire logic plate_on_btn,
  output logic plate_enable_contactor,
  output logic [3:0] fault_lamps,
  output logic plate_on_cmd,
  output logic recycle_pulse_lamp,
  output logic restart_blocked_lamp,
  output logic phase_ok_lamp,
  output logic cage_cover_ok_lamp,
  output logic airflow_ok_lamp,
  output logic exhaust_temp_ok_lamp,
  output logic ready_lamp,
  output logic power_on_cmd
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [`OLAR_SY_W-1:0] pins;
  logic [`OLAR_SY_W-1:0] ps;
  assign pins = {plate_on_btn, reflected_protect_enable, supply_ok, filament_on,
                 exhaust_temp_ok, airflow_ok, cage_cover_closed, phase_monitor_ok,
                 four_attempt_strap, recycle_test_btn, restart_allow_switch,
                 fault_reset_btn};

  olar_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(pins),
    .pins_s(ps)
  );

  olar_pkg::olar_state_s_t s_q;
  olar_pkg::olar_state_s_t n;

  // ----------------------------------------
  // overload compare and interlock chain
  // ----------------------------------------
  logic [3:0][`OLAR_LVL_W-1:0] cur;
  logic [3:0] trip;
  logic [3:0] gate;
  logic [3:0] ilk;
  logic [3:0] chain;
  assign cur[`OLAR_SRC_PLATE] = plate_current;
  assign cur[`OLAR_SRC_SCREEN] = screen_current;
  assign cur[`OLAR_SRC_REFL] = reflected_power;
  assign cur[`OLAR_SRC_DRIVER] = driver_current;
  // only the reflected source has a protect switch in its path
  assign gate = {1'b1, ps[`OLAR_SY_REFEN], 1'b1, 1'b1};
  assign ilk = {ps[`OLAR_SY_TEMP], ps[`OLAR_SY_AIR], ps[`OLAR_SY_CAGE], ps[`OLAR_SY_PHASE]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_src
      assign trip[gi] = (cur[gi] > s_q.lvl[gi]) && gate[gi];
      if (gi == 0) begin : g_head
        assign chain[gi] = ilk[gi];
      end else begin : g_link
        assign chain[gi] = chain[gi-1] && ilk[gi];
      end
    end
  endgenerate

  logic [3:0] fpulse;
  logic test_edge;
  logic trigger;
  logic ready_now;
  logic delay_done;
  logic win_end;
  logic [2:0] limit;
  logic [3:0] kept;
  assign fpulse = trip & ~s_q.trip_prev;
  assign test_edge = ps[`OLAR_SY_TEST] && !s_q.test_prev;
  assign trigger = (|fpulse) || test_edge;
  assign ready_now = chain[3] && s_q.warm_done && ps[`OLAR_SY_SUPPLY];
  assign delay_done = (s_q.st == olar_pkg::OLAR_DELAY) && (s_q.tmr == '0);
  assign win_end = s_q.win_run && (s_q.win_tmr == '0);
  assign limit = s_q.lim4 ? `OLAR_LIM4 : `OLAR_LIM2;
  assign kept = s_q.latch & trip;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = s_q;
    n.trip_prev = trip;
    n.test_prev = ps[`OLAR_SY_TEST];
    // strap is taken once the synchroniser has refilled after reset, then frozen
    if (s_q.strap_cnt != `OLAR_STRAP_WAIT) begin
      n.lim4 = ps[`OLAR_SY_STRAP];
      n.strap_cnt = s_q.strap_cnt + 2'h1;
    end
    // fault latches: set wins, reset cannot clear a source still tripped
    n.latch = fpulse | (s_q.latch & ~({4{ps[`OLAR_SY_FRST]}} & ~trip));
    // recycle sequencer
    case (s_q.st)
      olar_pkg::OLAR_IDLE: begin
        if (trigger && ps[`OLAR_SY_ALLOW] && !s_q.blocked) begin
          n.st = olar_pkg::OLAR_DELAY;
          n.tmr = olar_pkg::olar_stmr_t'(DELAY_CYC - 1);
          if (!s_q.win_run) begin
            n.win_run = 1'b1;
            n.win_tmr = olar_pkg::olar_ltmr_t'(WIN_CYC - 1);
          end
        end
      end
      olar_pkg::OLAR_DELAY: begin
        if (s_q.tmr == '0) begin
          n.st = olar_pkg::OLAR_PULSE;
          n.tmr = olar_pkg::olar_stmr_t'(PULSE_CYC - 1);
          n.rcnt = s_q.rcnt + 3'h1;
        end else begin
          n.tmr = s_q.tmr - 24'h1;
        end
      end
      olar_pkg::OLAR_PULSE: begin
        if (s_q.tmr == '0) begin
          n.st = olar_pkg::OLAR_IDLE;
        end else begin
          n.tmr = s_q.tmr - 24'h1;
        end
      end
      default: begin
        n.st = olar_pkg::OLAR_IDLE;
      end
    endcase
    if (!ps[`OLAR_SY_ALLOW]) begin
      n.st = olar_pkg::OLAR_IDLE;
    end
    // window timer; its expiry overrides a count taken in the same cycle
    if (s_q.win_run) begin
      n.win_tmr = s_q.win_tmr - 30'h1;
    end
    if (win_end) begin
      n.win_run = 1'b0;
      n.rcnt = 3'h0;
    end
    n.blocked = (n.rcnt >= limit);
    n.plate_on_cmd = (n.st == olar_pkg::OLAR_PULSE);
    n.pulse_lamp = (n.st == olar_pkg::OLAR_PULSE);
    // filament warm-up and outage ride-through
    if (!ps[`OLAR_SY_SUPPLY]) begin
      n.outage = 1'b1;
      if (!s_q.lost) begin
        n.hold = s_q.hold + 30'h1;
        // a long outage forgets the warm-up so ready cannot come back stale
        if (s_q.hold == olar_pkg::olar_ltmr_t'(HOLD_CYC - 1)) begin
          n.lost = 1'b1;
          n.warm = '0;
          n.warm_done = 1'b0;
        end
      end
    end else begin
      n.outage = 1'b0;
      n.lost = 1'b0;
      n.hold = '0;
      if (s_q.outage && !s_q.lost) begin
        n.pwr_cmd = 1'b1;
        n.pwr_tmr = olar_pkg::olar_stmr_t'(PULSE_CYC - 1);
      end
      if (chain[3] && ps[`OLAR_SY_FIL]) begin
        if (!s_q.warm_done) begin
          n.warm = s_q.warm + 30'h1;
          n.warm_done = (s_q.warm == olar_pkg::olar_ltmr_t'(WARM_CYC - 1));
        end
      end else begin
        n.warm = '0;
        n.warm_done = 1'b0;
      end
    end
    if (s_q.pwr_cmd) begin
      if (s_q.pwr_tmr == '0) begin
        n.pwr_cmd = 1'b0;
      end else begin
        n.pwr_tmr = s_q.pwr_tmr - 24'h1;
      end
    end
    n.lamps = {ready_now, chain};
    // plate contactor: seal-in held off by every trip in series
    n.plate_en = !(|trip) && ready_now &&
                 (s_q.plate_en || ps[`OLAR_SY_PLON] || s_q.plate_on_cmd || s_q.pwr_cmd);
    // register bus write side
    if (s_q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_q.awready) begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (n.aw_have && n.w_have && !n.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `OLAR_RESP_OK;
      if (n.awaddr[7:4] == 4'h0) begin
        if (n.wstrb[0]) begin
          n.lvl[n.awaddr[3:2]][7:0] = n.wdata[7:0];
        end
        if (n.wstrb[1]) begin
          n.lvl[n.awaddr[3:2]][11:8] = n.wdata[11:8];
        end
      end else if (n.awaddr != `OLAR_OFF_STATUS) begin
        n.bresp = `OLAR_RESP_DEC;
      end
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;
    // register bus read side
    if (s_q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `OLAR_RESP_OK;
      n.rdata = '0;
      if (s_axi_araddr[7:4] == 4'h0) begin
        n.rdata[`OLAR_LVL_W-1:0] = s_q.lvl[s_axi_araddr[3:2]];
      end else if (s_axi_araddr == `OLAR_OFF_STATUS) begin
        n.rdata[`OLAR_ST_LATCH] = s_q.latch;
        n.rdata[`OLAR_ST_BLOCK] = s_q.blocked;
        n.rdata[`OLAR_ST_COUNT] = s_q.rcnt;
        n.rdata[`OLAR_ST_READY] = s_q.lamps[4];
        n.rdata[`OLAR_ST_PLATE] = s_q.plate_en;
        n.rdata[`OLAR_ST_LIM4] = s_q.lim4;
      end else begin
        n.rresp = `OLAR_RESP_DEC;
      end
    end
    n.arready = !n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.lvl <= {4{`OLAR_LVL_RST}};
    end else begin
      s_q <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign plate_enable_contactor = s_q.plate_en;
  assign fault_lamps = s_q.latch;
  assign plate_on_cmd = s_q.plate_on_cmd;
  assign recycle_pulse_lamp = s_q.pulse_lamp;
  assign restart_blocked_lamp = s_q.blocked;
  assign phase_ok_lamp = s_q.lamps[0];
  assign cage_cover_ok_lamp = s_q.lamps[1];
  assign airflow_ok_lamp = s_q.lamps[2];
  assign exhaust_temp_ok_lamp = s_q.lamps[3];
  assign ready_lamp = s_q.lamps[4];
  assign power_on_cmd = s_q.pwr_cmd;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence delay_end_s;
    delay_done && ps[`OLAR_SY_ALLOW];
  endsequence
  sequence pulse_on_s;
    plate_on_cmd && recycle_pulse_lamp;
  endsequence

  trip_drops_plate_a: assert property (|trip |=> !plate_enable_contactor)
    else $error("plate enable held during a trip");
  latch_sets_a: assert property ($rose(trip[`OLAR_SRC_PLATE]) |=> fault_lamps[`OLAR_SRC_PLATE])
    else $error("plate fault latch not set by its pulse");
  lamp_holds_a: assert property (!ps[`OLAR_SY_FRST] |=> (fault_lamps & $past(fault_lamps)) == $past(fault_lamps))
    else $error("fault lamp cleared without fault reset");
  active_kept_a: assert property (ps[`OLAR_SY_FRST] |=> (fault_lamps & $past(kept)) == $past(kept))
    else $error("active fault cleared by reset");
  delay_to_pulse_a: assert property (delay_end_s |=> pulse_on_s)
    else $error("restart pulse missing after delay");
  pulse_needs_delay_a: assert property ($rose(plate_on_cmd) |-> $past(delay_done))
    else $error("restart pulse without finished delay");
  count_limit_a: assert property (s_q.rcnt <= limit)
    else $error("restart count above limit");
  lockout_blocks_a: assert property (restart_blocked_lamp && s_q.st == olar_pkg::OLAR_IDLE |=> s_q.st == olar_pkg::OLAR_IDLE)
    else $error("restart started while locked out");
  window_clears_a: assert property (win_end |=> s_q.rcnt == 3'h0 && !restart_blocked_lamp)
    else $error("window end left count or lockout");
  allow_off_a: assert property (!ps[`OLAR_SY_ALLOW] |=> s_q.st == olar_pkg::OLAR_IDLE ##1 !plate_on_cmd)
    else $error("restart active while disabled");
  chain_order_a: assert property (exhaust_temp_ok_lamp |-> airflow_ok_lamp && cage_cover_ok_lamp && phase_ok_lamp)
    else $error("interlock lamp lit out of order");
  ready_after_warm_a: assert property ($rose(plate_enable_contactor) |-> ready_lamp || $past(ready_now))
    else $error("plate enabled before warm-up");
endmodule

// *** sim/olar_panel.sv ***
// operator panel model: switches and buttons feeding the block's panel pins
`timescale 1ns/1ns
module olar_panel (
  input wire logic aclk,
  input wire logic [11:0] sw,
  output logic reflected_protect_enable,
  output logic fault_reset_btn,
  output logic restart_allow_switch,
  output logic recycle_test_btn,
  output logic four_attempt_strap,
  output logic phase_monitor_ok,
  output logic cage_cover_closed,
  output logic airflow_ok,
  output logic exhaust_temp_ok,
  output logic filament_on,
  output logic supply_ok,
  output logic plate_on_btn
);
  // ----
  // contacts
  // ----
  // contacts change on the clock; bounce is not modelled, and the block's two-flop synchroniser
  // only retimes the pins, so it would pass bounce through rather than hide it
  always @(posedge aclk) begin
    {plate_on_btn, supply_ok, filament_on, exhaust_temp_ok, airflow_ok, cage_cover_closed,
     phase_monitor_ok, four_attempt_strap, recycle_test_btn, restart_allow_switch,
     fault_reset_btn, reflected_protect_enable} <= sw;
  end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the overload latch and auto recycle block
`timescale 1ns/1ns
`include "olar_regs.svh"
module testbench;
  localparam int D = 4, P = 4, W = 64, WM = 16, H = 8;
  localparam int PROT = 0, FRST = 1, ALLOW = 2, TEST = 3, STRAP = 4, PHASE = 5;
  localparam int CAGE = 6, AIR = 7, TEMP = 8, FIL = 9, SUP = 10, PLON = 11;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, fault_lamps;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic reflected_protect_enable, fault_reset_btn, restart_allow_switch, recycle_test_btn;
  logic four_attempt_strap, phase_monitor_ok, cage_cover_closed, airflow_ok;
  logic exhaust_temp_ok, filament_on, supply_ok, plate_on_btn;
  logic plate_enable_contactor, plate_on_cmd, recycle_pulse_lamp, restart_blocked_lamp;
  logic phase_ok_lamp, cage_cover_ok_lamp, airflow_ok_lamp, exhaust_temp_ok_lamp;
  logic ready_lamp, power_on_cmd, pcmd_q = 1'b0;
  logic [11:0] sw = '0;
  logic [3:0][11:0] cur = '0;
  int n_fail = 0, num_checks = 0, npulse = 0, wid = 0, k;

  always #20 aclk = ~aclk;

  olar_panel i_panel (.aclk, .sw, .reflected_protect_enable, .fault_reset_btn,
    .restart_allow_switch, .recycle_test_btn, .four_attempt_strap, .phase_monitor_ok,
    .cage_cover_closed, .airflow_ok, .exhaust_temp_ok, .filament_on, .supply_ok,
    .plate_on_btn);
  olar_top #(.DELAY_CYC(D), .PULSE_CYC(P), .WIN_CYC(W), .WARM_CYC(WM), .HOLD_CYC(H))
  i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .plate_current(cur[0]), .screen_current(cur[1]),
    .driver_current(cur[2]), .reflected_power(cur[3]), .reflected_protect_enable,
    .fault_reset_btn, .restart_allow_switch, .recycle_test_btn, .four_attempt_strap,
    .phase_monitor_ok, .cage_cover_closed, .airflow_ok, .exhaust_temp_ok, .filament_on,
    .supply_ok, .plate_on_btn, .plate_enable_contactor, .fault_lamps, .plate_on_cmd,
    .recycle_pulse_lamp, .restart_blocked_lamp, .phase_ok_lamp, .cage_cover_ok_lamp,
    .airflow_ok_lamp, .exhaust_temp_ok_lamp, .ready_lamp, .power_on_cmd);

  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic pin(input int i, input logic v);
    @(posedge aclk);
    sw[i] <= v;
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk(s_axi_bresp, er);
        break;
      end
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        break;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----
  // restart pulse monitor
  // ----
  always @(posedge aclk) begin
    if (aresetn) begin
      chk(recycle_pulse_lamp, plate_on_cmd);
      if (plate_on_cmd === 1'b1 && !pcmd_q) npulse++;
      if (plate_on_cmd !== 1'b1 && pcmd_q) chk(wid, P);
      wid = (plate_on_cmd === 1'b1) ? wid + 1 : 0;
      pcmd_q = (plate_on_cmd === 1'b1);
    end
  end

  initial begin
    repeat (6000) @(posedge aclk);
    n_fail++;
    $display("timeout at %0t", $time);
    finish_test();
  end

  // ----
  // tests
  // ----
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    tick(3);
    rchk(`OLAR_OFF_PLATE, 32'h0000_0fff, `OLAR_RESP_OK);
    rchk(`OLAR_OFF_STATUS, 32'h0, `OLAR_RESP_OK);
    rchk(8'h14, 32'h0, `OLAR_RESP_DEC);
    wchk(8'h14, 32'h1, `OLAR_RESP_DEC);
    for (int i = 0; i < 4; i++) wchk(8'(i * 4), 32'h1234_5100, `OLAR_RESP_OK);
    for (int i = 0; i < 4; i++) rchk(8'(i * 4), 32'h0000_0100, `OLAR_RESP_OK);
    wchk(`OLAR_OFF_STATUS, 32'hffff_ffff, `OLAR_RESP_OK);
    rchk(`OLAR_OFF_STATUS, 32'h0, `OLAR_RESP_OK);
    // interlock chain stops at the open cage cover; closing it lights the remaining stages together
    pin(PHASE, 1); pin(AIR, 1); pin(TEMP, 1); pin(SUP, 1); pin(ALLOW, 1);
    tick(6);
    chk({phase_ok_lamp, cage_cover_ok_lamp, airflow_ok_lamp, exhaust_temp_ok_lamp}, 4'b1000);
    pin(CAGE, 1);
    tick(6);
    chk({phase_ok_lamp, cage_cover_ok_lamp, airflow_ok_lamp, exhaust_temp_ok_lamp}, 4'b1111);
    pin(FIL, 1); pin(PLON, 1); pin(PLON, 0);
    tick(6);
    chk({ready_lamp, plate_enable_contactor}, 2'b00);
    tick(WM);
    chk(ready_lamp, 1'b1);
    pin(PLON, 1); pin(PLON, 0);
    tick(6);
    chk(plate_enable_contactor, 1'b1);
    // level equal to the trip point is not an overload
    @(posedge aclk) cur[0] <= 12'h100;
    tick(3);
    chk({plate_enable_contactor, fault_lamps}, 5'b10000);
    // held overload gives one sequence only
    @(posedge aclk) cur[0] <= 12'h101;
    tick(1);
    chk({plate_enable_contactor, fault_lamps}, 5'b00001);
    for (k = 0; k < 50 && plate_on_cmd !== 1'b1; k++) tick(1);
    chk(k, D);
    tick(D + P + 8);
    @(posedge aclk) cur[0] <= 12'h000;
    tick(3);
    chk(npulse, 1);
    @(posedge aclk) cur[1] <= 12'hfff;
    @(posedge aclk) cur[1] <= 12'h000;
    tick(D + P + 4);
    chk({npulse[3:0], restart_blocked_lamp}, 5'b00101);
    // driver level on its own register: below it, no driver trip
    wchk(`OLAR_OFF_DRIVER, 32'h0000_0200, `OLAR_RESP_OK);
    @(posedge aclk) cur[2] <= 12'h180;
    tick(4);
    chk(fault_lamps, 4'b0011);
    @(posedge aclk) cur[2] <= 12'hfff;
    @(posedge aclk) cur[2] <= 12'h000;
    tick(D + P + 4);
    chk({npulse[3:0], fault_lamps, plate_enable_contactor}, 9'b0010_1011_0);
    tick(W);
    chk(restart_blocked_lamp, 1'b0);
    rchk(`OLAR_OFF_STATUS, 32'h0000_010b, `OLAR_RESP_OK);
    // reflected trip needs protect enable; allow off means no restart
    pin(ALLOW, 0);
    @(posedge aclk) cur[3] <= 12'hfff;
    tick(4);
    chk(fault_lamps, 4'b1011);
    pin(PROT, 1);
    tick(D + P + 8);
    chk({npulse[3:0], fault_lamps}, 8'b0010_1111);
    @(posedge aclk) cur[3] <= 12'h000;
    pin(PROT, 0);
    // fault reset while a source still trips
    @(posedge aclk) cur[1] <= 12'hfff;
    pin(FRST, 1);
    tick(4);
    pin(FRST, 0);
    tick(4);
    chk(fault_lamps, 4'b0010);
    @(posedge aclk) cur[1] <= 12'h000;
    pin(FRST, 1); pin(FRST, 0);
    tick(5);
    chk(fault_lamps, 4'b0000);
    // test button runs the restart without touching the latches
    pin(ALLOW, 1); pin(TEST, 1); pin(TEST, 0);
    for (k = 0; k < 50 && plate_on_cmd !== 1'b1; k++) tick(1);
    chk({plate_on_cmd, fault_lamps}, 5'b10000);
    tick(P + 3);
    chk({npulse[3:0], plate_enable_contactor}, 5'b00111);
    // short supply loss rides through warm-up and pulses power-on
    pin(SUP, 0);
    tick(3);
    pin(SUP, 1);
    for (k = 0; k < 40 && power_on_cmd !== 1'b1; k++) tick(1);
    chk(power_on_cmd, 1'b1);
    tick(P + 4);
    chk({ready_lamp, plate_enable_contactor}, 2'b11);
    pin(PHASE, 0);
    tick(6);
    chk({phase_ok_lamp, cage_cover_ok_lamp, airflow_ok_lamp, exhaust_temp_ok_lamp,
         ready_lamp}, 5'b00000);
    // strap read back after a fresh reset
    pin(STRAP, 1);
    @(posedge aclk) aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    tick(6);
    rchk(`OLAR_OFF_STATUS, 32'h0000_0400, `OLAR_RESP_OK);
    finish_test();
  end
endmodule
